// ### inc/epwm_defines.vh
// Functional notes
// - waveform has up to 10-bit duty resolution, routed to pins of the active mode
// - output mode field 00 gives single output, 10 gives half-bridge on both pins
// - module control bits 1 and 0 set the active polarity of output A and output B
// - after enabling, outputs wait for the next period start before any waveform
// - an all-zero module control register releases both pins to port logic
// - a pin unused by the selected mode is never driven by this block
// - shutdown raised by enabled sources: low interrupt pin, comparator, firmware setting status
// - shutdown status reads 0 in normal operation and 1 while outputs are shut down
// - a shutdown event sets status until firmware or auto-restart clears it
// - shutdown forces enabled pins to their safe states without waiting for a period
// - output A and output B each take high, low or tri-state from own field
`ifndef EPWM_DEFINES_VH
`define EPWM_DEFINES_VH

// register offsets
`define EPWM_ADDR_CTRL 8'h00
`define EPWM_ADDR_SHDN 8'h04
`define EPWM_ADDR_PERIOD 8'h08
`define EPWM_ADDR_DUTY 8'h0C
`define EPWM_ADDR_IRQ_STAT 8'h10
`define EPWM_ADDR_IRQ_MASK 8'h14

// module_control_reg fields
`define EPWM_CTRL_POL_B 0
`define EPWM_CTRL_POL_A 1
`define EPWM_CTRL_PWM_LSB 2
`define EPWM_CTRL_MODE_LSB 6
`define EPWM_CTRL_RESET 8'h00
`define EPWM_FUNC_PWM 2'h3
`define EPWM_MODE_SINGLE 2'h0
`define EPWM_MODE_HALF 2'h2

// shutdown_config_reg fields
`define EPWM_SHDN_B_LSB 0
`define EPWM_SHDN_A_LSB 2
`define EPWM_SHDN_SRC_INT 4
`define EPWM_SHDN_SRC_CMP 5
`define EPWM_SHDN_RESTART 6
`define EPWM_SHDN_STATUS 7
`define EPWM_SHDN_RESET 8'h00

// safe state codes
`define EPWM_SAFE_LOW 2'h0
`define EPWM_SAFE_HIGH 2'h1

// interrupt status bits
`define EPWM_IRQ_SHDN 0
`define EPWM_IRQ_PERIOD 1
`define EPWM_IRQ_RESET 2'h0

// period and duty reset values
`define EPWM_PERIOD_RESET 10'h3FF
`define EPWM_DUTY_RESET 10'h000

`endif

// ### design/epwm_period.v
`timescale 1ns/1ps
// free period counter with duty compare; idle and cleared while not running
module epwm_period #(
  parameter WIDTH = 10
) (
  input wire mclk,
  input wire resetn,
  input wire ce,
  input wire run,
  input wire [WIDTH-1:0] period,
  input wire [WIDTH-1:0] duty,
  output reg period_start,
  output reg pwm_raw
);

  reg [WIDTH-1:0] count;

  // count 0..period, pulse on wrap so the top knows a new period begins
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= {WIDTH{1'b0}};
      period_start <= 1'b0;
      pwm_raw <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count <= {WIDTH{1'b0}};
        period_start <= 1'b0;
        pwm_raw <= 1'b0;
      end else begin
        if (count == period) begin
          count <= {WIDTH{1'b0}};
          period_start <= 1'b1;
        end else begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
          period_start <= 1'b0;
        end
        pwm_raw <= (count < duty);
      end
    end
  end

endmodule // epwm_period

// ### design/epwm_top.v
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "epwm_defines.vh"

// enhanced pwm output stage with auto-shutdown
module epwm_top #(
  parameter RES = 10
) (
  input wire mclk,
  input wire resetn,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire int_pin,
  input wire cmp_out,
  input wire [1:0] pin_direction_control,
  output reg pwm_output_a_out,
  output reg pwm_output_a_oe,
  output reg pwm_output_b_out,
  output reg pwm_output_b_oe,
  output reg irq
);

  localparam ST_OFF = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [7:0] module_control_reg;
  reg [6:0] shdn_cfg;
  reg shutdown_event_status;
  reg [RES-1:0] period;
  reg [RES-1:0] duty;
  reg [1:0] irq_stat;
  reg [1:0] irq_mask;
  reg [2:0] state;
  reg [2:0] next_state;
  reg next_status;
  reg [1:0] next_irq_stat;
  reg next_a_out;
  reg next_a_oe;
  reg next_b_out;
  reg next_b_oe;
  reg [15:0] next_rdata;

  wire period_start;
  wire pwm_raw;
  wire [1:0] module_function_select;
  wire [1:0] output_mode_select;
  wire [1:0] output_a_shutdown_state;
  wire [1:0] output_b_shutdown_state;
  wire [1:0] shutdown_source_select;
  wire pwm_on;
  wire half;
  wire src_active;
  wire wr_shdn;
  wire wr_irq_stat;
  wire fw_set;
  wire fw_clr;
  wire restart;

  assign module_function_select = module_control_reg[`EPWM_CTRL_PWM_LSB+1:`EPWM_CTRL_PWM_LSB];
  assign output_mode_select = module_control_reg[`EPWM_CTRL_MODE_LSB+1:`EPWM_CTRL_MODE_LSB];
  assign output_a_shutdown_state = shdn_cfg[`EPWM_SHDN_A_LSB+1:`EPWM_SHDN_A_LSB];
  assign output_b_shutdown_state = shdn_cfg[`EPWM_SHDN_B_LSB+1:`EPWM_SHDN_B_LSB];
  assign shutdown_source_select = shdn_cfg[`EPWM_SHDN_SRC_CMP:`EPWM_SHDN_SRC_INT];
  assign pwm_on = (module_function_select == `EPWM_FUNC_PWM);
  assign half = (output_mode_select == `EPWM_MODE_HALF);

  // decoded write strobes
  assign wr_shdn = ce & wr & (addr == `EPWM_ADDR_SHDN);
  assign wr_irq_stat = ce & wr & (addr == `EPWM_ADDR_IRQ_STAT);

  // fault sources: low on the interrupt pin, high comparator output
  assign src_active = (shutdown_source_select[0] & ~int_pin) |
                      (shutdown_source_select[1] & cmp_out);
  assign fw_set = wr_shdn & wdata[`EPWM_SHDN_STATUS];
  assign fw_clr = wr_shdn & ~wdata[`EPWM_SHDN_STATUS];
  // restart only on a period boundary so the first pulse is whole
  assign restart = shdn_cfg[`EPWM_SHDN_RESTART - `EPWM_SHDN_B_LSB] & ~src_active &
                   period_start;

  epwm_period #(
    .WIDTH(RES)
  ) u_period (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .run(pwm_on),
    .period(period),
    .duty(duty),
    .period_start(period_start),
    .pwm_raw(pwm_raw)
  );

  // shutdown status: any set beats any clear in the same cycle
  always @* begin
    next_status = shutdown_event_status;
    if (src_active || fw_set) begin
      next_status = 1'b1;
    end else if (fw_clr || restart) begin
      next_status = 1'b0;
    end
  end

  // enable sequencing: hold off until a fresh period starts
  always @* begin
    case (state)
      ST_OFF: begin
        next_state = pwm_on ? ST_WAIT : ST_OFF;
      end
      ST_WAIT: begin
        if (!pwm_on) begin
          next_state = ST_OFF;
        end else if (period_start) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_RUN: begin
        next_state = pwm_on ? ST_RUN : ST_OFF;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // pin drive; shutdown uses the incoming status so it acts on the very next edge
  always @* begin
    next_a_out = 1'b0;
    next_a_oe = 1'b0;
    next_b_out = 1'b0;
    next_b_oe = 1'b0;
    if (module_control_reg == `EPWM_CTRL_RESET) begin
      next_a_oe = 1'b0;
      next_b_oe = 1'b0;
    end else if (next_status) begin
      // safe states hold while status stays set, source or not
      next_a_out = (output_a_shutdown_state == `EPWM_SAFE_HIGH);
      next_a_oe = ~output_a_shutdown_state[1] & pin_direction_control[0];
      next_b_out = (output_b_shutdown_state == `EPWM_SAFE_HIGH);
      next_b_oe = half & ~output_b_shutdown_state[1] &
                  pin_direction_control[1];
    end else if (state == ST_RUN) begin
      next_a_out = pwm_raw ^ module_control_reg[`EPWM_CTRL_POL_A];
      next_a_oe = pin_direction_control[0];
      // half-bridge drives the complement on output b
      next_b_out = ~pwm_raw ^ module_control_reg[`EPWM_CTRL_POL_B];
      next_b_oe = half & pin_direction_control[1];
    end
  end

  // interrupt events: shutdown entry and period start
  always @* begin
    next_irq_stat = irq_stat;
    if (wr_irq_stat) begin
      next_irq_stat = irq_stat & ~wdata[1:0];
    end
    if (next_status && !shutdown_event_status) begin
      next_irq_stat[`EPWM_IRQ_SHDN] = 1'b1;
    end
    if (period_start) begin
      next_irq_stat[`EPWM_IRQ_PERIOD] = 1'b1;
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = 16'h0000;
    case (addr)
      `EPWM_ADDR_CTRL: begin
        next_rdata = {8'h00, module_control_reg};
      end
      `EPWM_ADDR_SHDN: begin
        next_rdata = {8'h00, shutdown_event_status, shdn_cfg};
      end
      `EPWM_ADDR_PERIOD: begin
        next_rdata[RES-1:0] = period;
      end
      `EPWM_ADDR_DUTY: begin
        next_rdata[RES-1:0] = duty;
      end
      `EPWM_ADDR_IRQ_STAT: begin
        next_rdata = {14'h0000, irq_stat};
      end
      `EPWM_ADDR_IRQ_MASK: begin
        next_rdata = {14'h0000, irq_mask};
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // configuration registers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      module_control_reg <= `EPWM_CTRL_RESET;
      shdn_cfg <= 7'h00;
      period <= `EPWM_PERIOD_RESET;
      duty <= `EPWM_DUTY_RESET;
      irq_mask <= `EPWM_IRQ_RESET;
    end else if (ce && wr) begin
      case (addr)
        `EPWM_ADDR_CTRL: begin
          module_control_reg <= wdata[7:0];
        end
        `EPWM_ADDR_SHDN: begin
          shdn_cfg <= wdata[6:0];
        end
        `EPWM_ADDR_PERIOD: begin
          period <= wdata[RES-1:0];
        end
        `EPWM_ADDR_DUTY: begin
          duty <= wdata[RES-1:0];
        end
        `EPWM_ADDR_IRQ_MASK: begin
          irq_mask <= wdata[1:0];
        end
        default: begin
          period <= period;
        end
      endcase
    end
  end

  // state, status, pins and interrupt; read data lives one cycle only
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OFF;
      shutdown_event_status <= 1'b0;
      irq_stat <= `EPWM_IRQ_RESET;
      irq <= 1'b0;
      pwm_output_a_out <= 1'b0;
      pwm_output_a_oe <= 1'b0;
      pwm_output_b_out <= 1'b0;
      pwm_output_b_oe <= 1'b0;
      rdata <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      shutdown_event_status <= next_status;
      irq_stat <= next_irq_stat;
      irq <= |(next_irq_stat & irq_mask);
      pwm_output_a_out <= next_a_out;
      pwm_output_a_oe <= next_a_oe;
      pwm_output_b_out <= next_b_out;
      pwm_output_b_oe <= next_b_oe;
      rdata <= rd ? next_rdata : 16'h0000;
    end
  end

endmodule // epwm_top

// ### verif/epwm_far_side.sv
`timescale 1ns/1ps
// power stage inputs and fault sources facing the pwm pins
module epwm_far_side (
  input wire mclk,
  input wire a_out,
  input wire a_oe,
  input wire b_out,
  input wire b_oe,
  input wire ext_fault,
  input wire cmp_fault,
  output wire pad_a,
  output wire pad_b,
  output wire int_pin,
  output wire cmp_out
);
  reg flip = 1'b0;
  // undriven pads toggle so a released pin never passes for a held level
  always @(posedge mclk) flip <= ~flip;
  assign pad_a = a_oe ? a_out : flip;
  assign pad_b = b_oe ? b_out : ~flip;
  // fault line is active low, comparator trip active high
  assign int_pin = ~ext_fault;
  assign cmp_out = cmp_fault;
endmodule // epwm_far_side

// ### verif/epwm_checker.sv
`timescale 1ns/1ps
`include "epwm_defines.vh"
module epwm_checker (
  input wire mclk,
  input wire resetn,
  input wire ce,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire int_pin,
  input wire [1:0] pin_direction_control,
  input wire pwm_output_a_out,
  input wire pwm_output_a_oe,
  input wire pwm_output_b_oe,
  input wire irq
);
  reg [7:0] ctl;
  reg [7:0] sd;
  // shadow of software writes; pins are judged against what was programmed
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl <= 8'h00;
      sd <= 8'h00;
    end else if (ce && wr) begin
      if (addr == `EPWM_ADDR_CTRL) ctl <= wdata[7:0];
      if (addr == `EPWM_ADDR_SHDN) sd <= wdata[7:0];
    end
  end
  wire ena = ctl[3:2] == `EPWM_FUNC_PWM;
  // only faults on a running pin count, since the wait state drives nothing
  wire flt = ce && sd[4] && !int_pin && pwm_output_a_oe && ena;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ctl_read_a: assert property (ce && rd && addr == `EPWM_ADDR_CTRL
    |=> rdata == {8'h00, $past(ctl)}) else $error("control readback wrong");
  release_pins_a: assert property (ctl == 8'h00 && $past(ctl) == 8'h00
    |-> !pwm_output_a_oe && !pwm_output_b_oe) else $error("pins held after release");
  single_b_a: assert property (ctl[7:6] != 2'h2 && $past(ctl[7:6]) != 2'h2
    |-> !pwm_output_b_oe) else $error("pin b driven outside half-bridge");
  dir_gate_a: assert property (!pin_direction_control[0]
    && !$past(pin_direction_control[0]) |-> !pwm_output_a_oe) else $error("a driven as input");
  wait_low_a: assert property ($rose(ena) |-> (!pwm_output_a_oe)[*8])
    else $error("pin a driven before period start");
  wait_end_a: assert property ($rose(ena) && pin_direction_control[0]
    |-> ##[8:40] pwm_output_a_oe) else $error("pin a never started");
  safe_high_a: assert property (flt && sd[3:2] == `EPWM_SAFE_HIGH
    |-> ##[1:3] pwm_output_a_oe && pwm_output_a_out) else $error("a not forced high");
  safe_tri_a: assert property (flt && sd[1] |-> ##[1:3] !pwm_output_b_oe)
    else $error("b not released on fault");
  cover property (flt);
  cover property ($rose(pwm_output_b_oe));
  cover property ($rose(irq));
endmodule // epwm_checker
bind epwm_top epwm_checker epwm_checker_i (.mclk(mclk), .resetn(resetn), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .int_pin(int_pin),
  .pin_direction_control(pin_direction_control), .pwm_output_a_out(pwm_output_a_out),
  .pwm_output_a_oe(pwm_output_a_oe), .pwm_output_b_oe(pwm_output_b_oe), .irq(irq));

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "epwm_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [1:0] dir = 2'h3;
  reg ext_f = 1'b0;
  reg cmp_f = 1'b0;
  reg ce = 1'b1;
  wire [15:0] rdata;
  wire a_out, a_oe, b_out, b_oe, irq, int_pin, cmp_out, pad_a, pad_b;
  integer n_errors = 0;
  integer n_tests = 0;
  integer i, k;
  always #12.5 mclk = ~mclk;
  // clock enable is dropped once to show that a frozen block refuses writes
  epwm_top epwm_top_i (.mclk(mclk), .resetn(resetn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .int_pin(int_pin), .cmp_out(cmp_out),
    .pin_direction_control(dir), .pwm_output_a_out(a_out), .pwm_output_a_oe(a_oe),
    .pwm_output_b_out(b_out), .pwm_output_b_oe(b_oe), .irq(irq));
  epwm_far_side epwm_far_side_i (.mclk(mclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out),
    .b_oe(b_oe), .ext_fault(ext_f), .cmp_fault(cmp_f), .pad_a(pad_a), .pad_b(pad_b),
    .int_pin(int_pin), .cmp_out(cmp_out));
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wreg(input [7:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
    end
  endtask
  // read data lands at the edge after the strobe and stands only there
  task rreg(input [7:0] a, input [15:0] e);
    begin
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  // bounded wait for pin a, then a full period to settle
  task wait_oe;
    begin
      for (k = 0; k < 60 && a_oe !== 1'b1; k++) @(posedge mclk);
      if (k == 60) begin
        n_errors++;
        print_verdict;
      end
      tick(17);
    end
  endtask
  // high cycles of pad a over one 16-cycle period; b is the complement of a
  task duty(input [4:0] e);
    begin
      k = 0;
      for (i = 0; i < 16; i++) begin
        @(posedge mclk);
        #1 k = k + pad_a;
        `CHK(pad_b, ~pad_a)
      end
      `CHK(k[4:0], e)
    end
  endtask
  initial begin
    tick(12);
    resetn <= 1'b1;
    rreg(`EPWM_ADDR_CTRL, 16'h0000);
    rreg(`EPWM_ADDR_SHDN, 16'h0000);
    rreg(`EPWM_ADDR_PERIOD, 16'h03FF);
    rreg(8'h1C, 16'h0000);
    $display("test reset done");
    wreg(`EPWM_ADDR_PERIOD, 16'h000F);
    wreg(`EPWM_ADDR_DUTY, 16'h0004);
    wreg(`EPWM_ADDR_CTRL, 16'h008C);
    #1 `CHK(a_oe, 1'b0)
    wait_oe;
    duty(5'd4);
    wreg(`EPWM_ADDR_CTRL, 16'h008F);
    tick(17);
    duty(5'd12);
    wreg(`EPWM_ADDR_CTRL, 16'h000C);
    wait_oe;
    #1 `CHK({a_oe, b_oe}, 2'b10)
    $display("test modes done");
    // frozen block takes no write, so duty must still read back 4
    @(posedge mclk) ce <= 1'b0;
    wreg(`EPWM_ADDR_DUTY, 16'h0009);
    @(posedge mclk) ce <= 1'b1;
    rreg(`EPWM_ADDR_DUTY, 16'h0004);
    $display("test freeze done");
    wreg(`EPWM_ADDR_CTRL, 16'h008C);
    wreg(`EPWM_ADDR_SHDN, 16'h0016);
    tick(20);
    ext_f <= 1'b1;
    tick(3);
    #1 `CHK({a_oe, pad_a, b_oe}, 3'b110)
    @(posedge mclk) ext_f <= 1'b0;
    tick(20);
    #1 `CHK({a_oe, pad_a, b_oe}, 3'b110)
    rreg(`EPWM_ADDR_SHDN, 16'h0096);
    wreg(`EPWM_ADDR_SHDN, 16'h0016);
    tick(20);
    #1 `CHK(b_oe, 1'b1)
    rreg(`EPWM_ADDR_SHDN, 16'h0016);
    $display("test pin fault done");
    wreg(`EPWM_ADDR_SHDN, 16'h0061);
    tick(17);
    cmp_f <= 1'b1;
    tick(20);
    #1 `CHK({pad_a, pad_b}, 2'b01)
    wreg(`EPWM_ADDR_IRQ_MASK, 16'h0001);
    tick(2);
    #1 `CHK(irq, 1'b1)
    @(posedge mclk) cmp_f <= 1'b0;
    tick(40);
    rreg(`EPWM_ADDR_SHDN, 16'h0061);
    wreg(`EPWM_ADDR_IRQ_STAT, 16'h0003);
    tick(2);
    #1 `CHK(irq, 1'b0)
    // period start flag is sticky and comes back within one 16-cycle period
    tick(16);
    rreg(`EPWM_ADDR_IRQ_STAT, 16'h0002);
    $display("test restart done");
    wreg(`EPWM_ADDR_SHDN, 16'h008A);
    tick(2);
    #1 `CHK({a_oe, b_oe}, 2'b00)
    wreg(`EPWM_ADDR_SHDN, 16'h0000);
    tick(20);
    @(posedge mclk) dir <= 2'h2;
    tick(3);
    #1 `CHK(a_oe, 1'b0)
    wreg(`EPWM_ADDR_CTRL, 16'h0000);
    tick(2);
    #1 `CHK({a_oe, b_oe}, 2'b00)
    $display("test release done");
    print_verdict;
  end
endmodule // testbench
